// ==== fwp_top.sv ====
// Operation
// - Each OTP lock byte guards eight regions, LSB lowest, next byte next eight.
// - Lock bit zero guards upper sixteen bytes of region zero, holding lock bytes.
// - Write enable command sets the write enable latch.
// - Latch clears at reset and on completing each listed modifying command.
// - Three-bit block protect code selects none, 1/64 up to half, or all.
// - Bottom select zero places protected range at top, one at bottom.
// - Sector protected when block or sector protection says so; refuse program, erase.
// - Freeze holds block protect controls and OTP area until power cycle.
// - Write protect pin low with status write disable blocks register writes.
// - Each sector has persistent and dynamic bit; either zero protects it.
// - Lock zero refuses program and erase of persistent sector bits.
// - Persistent mode sets lock to one at power-on and hardware reset.
// - Persistent mode: lock write clears lock; nothing sets it until reset.
// - Password mode clears lock at hardware reset; power-on loads lock one and mode 11.
// - Password mode sets lock only when supplied 64-bit password matches.
// - Password mode lock write clears the lock again.
// - Lock management mode comes from one-time programmable mode bits.
// - Mode 11 default persistent, 10 persistent, 01 password; making 00 fails.
// - Persistent bits program to zero singly, erase all to one together.
`timescale 1ns/1ps
module fwp_top #(
  parameter int NUM_SECTORS = 64
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire fwp_pkg::fwp_apb_req_s apbReq,
  output fwp_pkg::fwp_apb_rsp_s apbRsp,
  input wire logic wpPinN,
  input wire logic hwResetPinN,
  output fwp_pkg::fwp_op_req_s opReq,
  output logic [NUM_SECTORS-1:0] sectorProt
);

  localparam int SW = $clog2(NUM_SECTORS);

  if (NUM_SECTORS < fwp_pkg::MIN_SECTORS || (NUM_SECTORS & (NUM_SECTORS - 1)) != 0) begin : g_chk
    $error("NUM_SECTORS must be a power of two of at least 64");
  end

  typedef enum logic {FWP_IDLE, FWP_EXEC} fwp_st_e;

  typedef struct packed {
    fwp_st_e st;
    fwp_pkg::fwp_cmd_e cmd;
    logic [31:0] arg;
    logic [fwp_pkg::PASS_W-1:0] passBuf;
    logic [fwp_pkg::PASS_W-1:0] passStore;
    logic write_enable_latch;
    logic status_write_disable;
    logic [fwp_pkg::BP_W-1:0] bp;
    logic bottom;
    logic freeze;
    logic [1:0] mode;
    logic lock;
    logic [NUM_SECTORS-1:0] psb;
    logic [NUM_SECTORS-1:0] dsb;
    logic [NUM_SECTORS-1:0] prot;
    logic [fwp_pkg::OTP_REGIONS-1:0] lockBits;
    logic granted;
    logic refused;
    fwp_pkg::fwp_op_req_s op;
    fwp_pkg::fwp_apb_rsp_s rsp;
  } fwp_state_s;

  fwp_state_s q;
  fwp_state_s d;

  logic [1:0] pinSync;
  logic wpLow;
  logic hwRstN;
  logic [NUM_SECTORS-1:0] blockVec;

  // ----------------------------------------
  // Pin synchronisers and block range decode
  // ----------------------------------------
  fwp_pin_sync #(.W(2), .RST(2'h3)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .pinIn({hwResetPinN, wpPinN}),
    .pinOut(pinSync)
  );

  assign wpLow = !pinSync[0];
  assign hwRstN = pinSync[1];

  fwp_block_decode #(.NUM_SECTORS(NUM_SECTORS)) u_dec (
    .bpField(q.bp),
    .bottomSel(q.bottom),
    .blockProt(blockVec)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic acc;
  logic ok;
  logic [SW-1:0] sec;
  logic [fwp_pkg::OTP_AW-1:0] otpAddr;
  logic otpGuard;
  logic [1:0] newMode;
  logic [4:0] region;

  always_comb begin
    d = q;
    d.rsp.pready = 1'b0;
    d.rsp.pslverr = 1'b0;
    d.op.go = 1'b0;
    acc = apbReq.psel && apbReq.penable;
    sec = q.arg[SW-1:0];
    otpAddr = q.arg[fwp_pkg::OTP_AW-1:0];
    region = otpAddr[fwp_pkg::OTP_AW-1:fwp_pkg::OTP_REGION_LSB];
    ok = 1'b0;
    newMode = q.mode & q.arg[fwp_pkg::MODE_LSB +: 2];
    // Region zero lower half holds factory data, only its upper half is guarded
    if (region == '0) begin
      otpGuard = otpAddr[fwp_pkg::OTP_HALF_BIT] && !q.lockBits[0];
    end else begin
      otpGuard = !q.lockBits[region];
    end
    // Sector view is a cycle late; a command never runs back to back with the one before
    d.prot = blockVec | ~q.psb | ~q.dsb;

    // APB: one wait state, answer prepared in the first access cycle
    if (acc && !q.rsp.pready) begin
      d.rsp.pready = 1'b1;
      d.rsp.prdata = '0;
      unique case (apbReq.paddr)
        fwp_pkg::REG_CMD: begin
          d.rsp.prdata[fwp_pkg::CMD_W-1:0] = q.cmd;
          d.rsp.pslverr = apbReq.pwrite && (q.st != FWP_IDLE);
        end
        fwp_pkg::REG_ARG: d.rsp.prdata = q.arg;
        fwp_pkg::REG_PASS_LO: d.rsp.prdata = '0;
        fwp_pkg::REG_PASS_HI: d.rsp.prdata = '0;
        fwp_pkg::REG_STATUS: begin
          d.rsp.prdata[fwp_pkg::ST_STATUS_WRITE_DISABLE] = q.status_write_disable;
          d.rsp.prdata[fwp_pkg::ST_BP_LSB +: fwp_pkg::BP_W] = q.bp;
          d.rsp.prdata[fwp_pkg::ST_WEL] = q.write_enable_latch;
        end
        fwp_pkg::REG_CONFIG: begin
          d.rsp.prdata[fwp_pkg::CFG_BOTTOM] = q.bottom;
          d.rsp.prdata[fwp_pkg::CFG_FREEZE] = q.freeze;
        end
        fwp_pkg::REG_MODE: d.rsp.prdata[fwp_pkg::MODE_LSB +: 2] = q.mode;
        fwp_pkg::REG_SECTOR: begin
          d.rsp.prdata[fwp_pkg::SEC_PROT] = q.prot[sec];
          d.rsp.prdata[fwp_pkg::SEC_PSB] = q.psb[sec];
          d.rsp.prdata[fwp_pkg::SEC_DSB] = q.dsb[sec];
          d.rsp.prdata[fwp_pkg::SEC_PROT + 1] = q.lock;
        end
        fwp_pkg::REG_OTP_LOCK: d.rsp.prdata = q.lockBits;
        fwp_pkg::REG_RESULT: begin
          d.rsp.prdata[fwp_pkg::RES_BUSY] = (q.st != FWP_IDLE);
          d.rsp.prdata[fwp_pkg::RES_REFUSED] = q.refused;
          d.rsp.prdata[fwp_pkg::RES_GRANTED] = q.granted;
        end
        default: d.rsp.pslverr = 1'b1;
      endcase
    end

    // Writes take effect on the completing edge
    if (acc && q.rsp.pready && apbReq.pwrite && !q.rsp.pslverr) begin
      unique case (apbReq.paddr)
        fwp_pkg::REG_CMD: begin
          d.cmd = fwp_pkg::fwp_cmd_e'(apbReq.pwdata[fwp_pkg::CMD_W-1:0]);
          d.st = FWP_EXEC;
          d.granted = 1'b0;
          d.refused = 1'b0;
        end
        fwp_pkg::REG_ARG: d.arg = apbReq.pwdata;
        fwp_pkg::REG_PASS_LO: d.passBuf[31:0] = apbReq.pwdata;
        fwp_pkg::REG_PASS_HI: d.passBuf[63:32] = apbReq.pwdata;
        default: d.arg = q.arg;
      endcase
    end

    // Command execution, one cycle
    if (q.st == FWP_EXEC) begin
      d.st = FWP_IDLE;
      unique case (q.cmd)
        fwp_pkg::CMD_WRITE_ENABLE_CMD: begin
          d.write_enable_latch = 1'b1;
          ok = 1'b1;
        end
        fwp_pkg::CMD_WRITE_DISABLE_CMD, fwp_pkg::CMD_SOFT_RESET: begin
          d.write_enable_latch = 1'b0;
          ok = 1'b1;
        end
        fwp_pkg::CMD_PROGRAM, fwp_pkg::CMD_ERASE_4K, fwp_pkg::CMD_ERASE_SECTOR: begin
          ok = q.write_enable_latch && !q.prot[sec];
          d.op.go = ok;
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_ERASE_BULK: begin
          ok = q.write_enable_latch && !(|q.prot);
          d.op.go = ok;
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_REG_WRITE: begin
          ok = q.write_enable_latch && !(wpLow && q.status_write_disable);
          if (ok) begin
            d.status_write_disable = q.arg[fwp_pkg::ST_STATUS_WRITE_DISABLE];
            d.freeze = q.freeze | q.arg[fwp_pkg::CFG_LSB + fwp_pkg::CFG_FREEZE];
            if (!q.freeze) begin
              d.bp = q.arg[fwp_pkg::ST_BP_LSB +: fwp_pkg::BP_W];
              d.bottom = q.arg[fwp_pkg::CFG_LSB + fwp_pkg::CFG_BOTTOM];
            end
          end
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_OTP_PROG: begin
          ok = q.write_enable_latch && !q.freeze && !otpGuard;
          d.op.go = ok;
          if (ok && otpAddr[fwp_pkg::OTP_AW-1:2] == fwp_pkg::LOCK_BYTE_BASE[9:2]) begin
            d.lockBits[{otpAddr[1:0], 3'h0} +: 8] =
              q.lockBits[{otpAddr[1:0], 3'h0} +: 8] & q.arg[fwp_pkg::ARG_DATA_LSB +: 8];
          end
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_PSB_PROG: begin
          ok = q.write_enable_latch && q.lock;
          if (ok) begin
            d.psb[sec] = 1'b0;
          end
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_PSB_ERASE: begin
          ok = q.write_enable_latch && q.lock;
          if (ok) begin
            d.psb = '1;
          end
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_DSB_WRITE: begin
          ok = 1'b1;
          d.dsb[sec] = q.arg[fwp_pkg::ARG_DATA_LSB];
        end
        fwp_pkg::CMD_LOCK_WRITE: begin
          ok = 1'b1;
          d.lock = 1'b0;
        end
        fwp_pkg::CMD_PASS_UNLOCK: begin
          ok = (q.mode == fwp_pkg::MODE_PASSWORD) && (q.passBuf == q.passStore);
          if (ok) begin
            d.lock = 1'b1;
          end
        end
        fwp_pkg::CMD_PASS_PROG: begin
          ok = q.write_enable_latch && (q.mode == fwp_pkg::MODE_DEFAULT);
          if (ok) begin
            d.passStore = q.passStore & q.passBuf;
          end
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_GUARD_PROG: begin
          ok = q.write_enable_latch && (q.mode == fwp_pkg::MODE_DEFAULT)
            && (newMode != fwp_pkg::MODE_ILLEGAL);
          if (ok) begin
            d.mode = newMode;
          end
          d.write_enable_latch = 1'b0;
        end
        fwp_pkg::CMD_LEARN_PROG: begin
          ok = q.write_enable_latch;
          d.write_enable_latch = 1'b0;
        end
        // CMD_NONE and codes above the last command land here
        default: ok = 1'b0;
      endcase
      d.granted = ok;
      d.refused = !ok;
      d.op.op = q.cmd;
      d.op.target = q.arg[15:0];
      d.op.data = q.arg[fwp_pkg::ARG_DATA_LSB +: 8];
    end

    // Hardware reset pin: volatile protection state only, freeze survives
    if (!hwRstN) begin
      d.st = FWP_IDLE;
      d.op.go = 1'b0;
      d.write_enable_latch = 1'b0;
      d.dsb = '1;
      d.lock = (q.mode != fwp_pkg::MODE_PASSWORD);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= FWP_IDLE;
      q.passStore <= '1;
      q.mode <= fwp_pkg::MODE_DEFAULT;
      q.lock <= 1'b1;
      q.psb <= '1;
      q.dsb <= '1;
      q.lockBits <= '1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign apbRsp = q.rsp;
  assign opReq = q.op;
  assign sectorProt = q.prot;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wel_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && q.st == FWP_EXEC && q.cmd == fwp_pkg::CMD_WRITE_ENABLE_CMD && hwRstN) |=> q.write_enable_latch)
    else $error("latch not set by write enable");

  wel_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && q.st == FWP_EXEC && (q.cmd == fwp_pkg::CMD_PROGRAM || q.cmd == fwp_pkg::CMD_WRITE_DISABLE_CMD ||
     q.cmd == fwp_pkg::CMD_REG_WRITE || q.cmd == fwp_pkg::CMD_OTP_PROG)) |=> !q.write_enable_latch)
    else $error("latch not cleared after command");

  op_guard_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (q.op.go && q.op.op == fwp_pkg::CMD_PROGRAM) |->
      $past(q.write_enable_latch) && !$past(q.prot[q.arg[SW-1:0]]))
    else $error("program started on protected sector");

  freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    q.freeze |=> ($stable(q.bp) && $stable(q.bottom) && $stable(q.lockBits) && q.freeze))
    else $error("frozen controls changed");

  wp_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && q.st == FWP_EXEC && q.cmd == fwp_pkg::CMD_REG_WRITE && wpLow && q.status_write_disable)
      |=> ($stable(q.status_write_disable) && $stable(q.bp) && $stable(q.bottom) && $stable(q.freeze)))
    else $error("register changed under write protect");

  lock_stays_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!q.lock && q.mode != fwp_pkg::MODE_PASSWORD && hwRstN) |=> !q.lock)
    else $error("lock set without reset in persistent mode");

  psb_locked_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !q.lock |=> $stable(q.psb))
    else $error("persistent bits changed while locked");

  unlock_match_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($rose(q.lock) && hwRstN) |->
      ($past(q.passBuf) == $past(q.passStore) && $past(q.mode) == fwp_pkg::MODE_PASSWORD))
    else $error("lock set without password match");

  mode_fixed_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (q.mode != fwp_pkg::MODE_DEFAULT) |=> ($stable(q.mode) && q.mode != fwp_pkg::MODE_ILLEGAL))
    else $error("mode field changed after selection");

  hw_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && !hwRstN) |=> (q.lock == ($past(q.mode) != fwp_pkg::MODE_PASSWORD)) && !q.write_enable_latch)
    else $error("hardware reset lock value wrong");

endmodule

// ==== fwp_pkg.sv ====
package fwp_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_PASS_LO = 8'h08;
  localparam logic [7:0] REG_PASS_HI = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  localparam logic [7:0] REG_MODE = 8'h18;
  localparam logic [7:0] REG_SECTOR = 8'h1C;
  localparam logic [7:0] REG_OTP_LOCK = 8'h20;
  localparam logic [7:0] REG_RESULT = 8'h24;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int ST_STATUS_WRITE_DISABLE = 7;
  localparam int ST_BP_LSB = 2;
  localparam int ST_WEL = 1;
  localparam int CFG_LSB = 8;
  localparam int CFG_BOTTOM = 5;
  localparam int CFG_FREEZE = 0;
  localparam int MODE_LSB = 1;
  localparam int ARG_DATA_LSB = 16;
  localparam int SEC_PROT = 2;
  localparam int SEC_PSB = 1;
  localparam int SEC_DSB = 0;
  localparam int RES_BUSY = 2;
  localparam int RES_REFUSED = 1;
  localparam int RES_GRANTED = 0;
  localparam int CMD_W = 5;
  localparam int BP_W = 3;
  localparam int OTP_AW = 10;
  localparam int OTP_REGION_LSB = 5;
  localparam int OTP_HALF_BIT = 4;
  localparam int OTP_REGIONS = 32;
  localparam int PASS_W = 64;
  localparam int MIN_SECTORS = 64;

  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [1:0] MODE_DEFAULT = 2'h3;
  localparam logic [1:0] MODE_PERSIST = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h0;
  localparam logic [9:0] LOCK_BYTE_BASE = 10'h010;
  localparam logic [BP_W-1:0] BP_ALL = 3'h7;

  typedef enum logic [CMD_W-1:0] {
    CMD_NONE, CMD_WRITE_ENABLE_CMD, CMD_WRITE_DISABLE_CMD, CMD_PROGRAM, CMD_ERASE_4K, CMD_ERASE_SECTOR,
    CMD_ERASE_BULK, CMD_REG_WRITE, CMD_OTP_PROG, CMD_PSB_PROG, CMD_PSB_ERASE,
    CMD_DSB_WRITE, CMD_LOCK_WRITE, CMD_PASS_UNLOCK, CMD_PASS_PROG, CMD_GUARD_PROG,
    CMD_LEARN_PROG, CMD_SOFT_RESET
  } fwp_cmd_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fwp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fwp_apb_rsp_s;

  typedef struct packed {
    logic go;
    fwp_cmd_e op;
    logic [15:0] target;
    logic [7:0] data;
  } fwp_op_req_s;

endpackage

// ==== fwp_pin_sync.sv ====
`timescale 1ns/1ps
module fwp_pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } fwp_sync_s;

  fwp_sync_s q;
  fwp_sync_s d;

  // ----------------------------------------
  // Filter: accept a level once stages two and three agree
  // ----------------------------------------
  always_comb begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.out[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q.s1 <= RST;
      q.s2 <= RST;
      q.s3 <= RST;
      q.out <= RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pinOut = q.out;

endmodule

// ==== fwp_block_decode.sv ====
`timescale 1ns/1ps
module fwp_block_decode #(
  parameter int NUM_SECTORS = 64
) (
  input wire logic [fwp_pkg::BP_W-1:0] bpField,
  input wire logic bottomSel,
  output logic [NUM_SECTORS-1:0] blockProt
);

  localparam int CW = $clog2(NUM_SECTORS) + 1;

  logic [CW-1:0] count;

  // ----------------------------------------
  // Protected sector count: none for code zero, else all sectors shifted right by (7 - code)
  // ----------------------------------------
  always_comb begin
    if (bpField == '0) begin
      count = '0;
    end else begin
      count = CW'(NUM_SECTORS >> (fwp_pkg::BP_ALL - bpField));
    end
  end

  for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_sec
    always_comb begin
      if (bottomSel) begin
        blockProt[s] = (CW'(s) < count);
      end else begin
        blockProt[s] = (CW'(s) >= (CW'(NUM_SECTORS) - count));
      end
    end
  end

endmodule

// ==== fwp_host_model.sv ====
`timescale 1ns/1ps
module fwp_host_model (
  input wire logic clk_sys,
  output fwp_pkg::fwp_apb_req_s apbReq,
  input wire fwp_pkg::fwp_apb_rsp_s apbRsp
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial apbReq = '0;

  // Request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    xfer(1'b0, a, 32'h0, d, e);
  endtask

  // ----------------------------------------
  // Flash commands
  // ----------------------------------------
  // Next command only after busy drops
  task automatic cmd(input fwp_pkg::fwp_cmd_e c, input logic [31:0] arg,
      output logic [31:0] res);
    wr(fwp_pkg::REG_ARG, arg);
    wr(fwp_pkg::REG_CMD, 32'(c));
    do begin
      rd(fwp_pkg::REG_RESULT, res);
    end while (res[fwp_pkg::RES_BUSY] === 1'b1);
  endtask

  task automatic mcmd(input fwp_pkg::fwp_cmd_e c, input logic [31:0] arg,
      output logic [31:0] res);
    logic [31:0] r;
    cmd(fwp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, r);
    cmd(c, arg, res);
  endtask
endmodule

// ==== test_flash_write_protection.sv ====
`timescale 1ns/1ps
module test_flash_write_protection;
  localparam int NS = 64;
  logic clk_sys;
  logic rstn;
  logic ce;
  logic wpPinN;
  logic hwResetPinN;
  fwp_pkg::fwp_apb_req_s apbReq;
  fwp_pkg::fwp_apb_rsp_s apbRsp;
  fwp_pkg::fwp_op_req_s opReq;
  logic [NS-1:0] sectorProt;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int goCount = 0;
  int g;
  logic [31:0] r;
  logic e;

  fwp_top #(.NUM_SECTORS(NS)) fwp_top_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .apbReq(apbReq), .apbRsp(apbRsp), .wpPinN(wpPinN), .hwResetPinN(hwResetPinN),
    .opReq(opReq), .sectorProt(sectorProt));
  fwp_host_model fwp_host_model_inst (.clk_sys(clk_sys), .apbReq(apbReq), .apbRsp(apbRsp));

  // ----------------------------------------
  // Clock, watchdog, go monitor
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (opReq.go === 1'b1) goCount++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected at %0t: run hung", $time);
      close_out();
    end
  end

  // ----------------------------------------
  // Compare and helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Outcome of a command: granted or refused
  task automatic chkRes(input logic [31:0] res, input logic gr);
    check_count++;
    if (res[1:0] !== {~gr, gr}) begin
      num_errors++;
      $display("unexpected at %0t: result %h", $time, res);
    end
  endtask

  task automatic run(input fwp_pkg::fwp_cmd_e c, input logic [31:0] a, input logic m,
      input logic gr);
    logic [31:0] res;
    if (m) fwp_host_model_inst.mcmd(c, a, res);
    else fwp_host_model_inst.cmd(c, a, res);
    chkRes(res, gr);
  endtask

  task automatic sec(input int i);
    fwp_host_model_inst.wr(fwp_pkg::REG_ARG, 32'(i));
    fwp_host_model_inst.rd(fwp_pkg::REG_SECTOR, r);
  endtask

  task automatic rdr(input logic [7:0] a);
    fwp_host_model_inst.rd(a, r);
  endtask

  // Pin is filtered, so hold it well past the sync depth
  task automatic hwrst();
    @(posedge clk_sys) hwResetPinN <= 1'b0;
    repeat (8) @(posedge clk_sys);
    hwResetPinN <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  // Enable low freezes every flop, the filter included
  task automatic frozen_rst();
    @(posedge clk_sys) ce <= 1'b0;
    hwrst();
    @(posedge clk_sys) ce <= 1'b1;
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_wel();
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 0);
    run(fwp_pkg::CMD_WRITE_ENABLE_CMD, 0, 0, 1);
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 1);
    run(fwp_pkg::CMD_WRITE_DISABLE_CMD, 0, 0, 1);
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 0);
    g = goCount;
    run(fwp_pkg::CMD_PROGRAM, 9, 0, 0);
    chk(goCount - g, 0);
    run(fwp_pkg::CMD_PROGRAM, 9, 1, 1);
    chk(goCount - g, 1);
    chk(opReq.op, fwp_pkg::CMD_PROGRAM);
    chk(opReq.target, 16'h9);
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 0);
    run(fwp_pkg::CMD_SOFT_RESET, 0, 1, 1);
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 0);
    fwp_host_model_inst.xfer(1'b0, 8'h28, 32'h0, r, e);
    chk(e, 1);
  endtask

  task automatic t_block();
    logic [63:0] m;
    int n;
    for (int b = 0; b < 2; b++) begin
      for (int bp = 0; bp < 8; bp++) begin
        run(fwp_pkg::CMD_REG_WRITE, {16'h0, 8'(b << 5), 8'(bp << 2)}, 1, 1);
        n = (bp == 0) ? 0 : (1 << (bp - 1));
        m = (64'h1 << n) - 64'h1;
        if (b == 0) m = m << (64 - n);
        chk(sectorProt, m);
      end
    end
    run(fwp_pkg::CMD_REG_WRITE, 32'h200C, 1, 1);
    run(fwp_pkg::CMD_PROGRAM, 2, 1, 0);
    run(fwp_pkg::CMD_ERASE_4K, 3, 1, 0);
    run(fwp_pkg::CMD_ERASE_BULK, 0, 1, 0);
    run(fwp_pkg::CMD_PROGRAM, 4, 1, 1);
    run(fwp_pkg::CMD_ERASE_SECTOR, 5, 1, 1);
    run(fwp_pkg::CMD_REG_WRITE, 0, 1, 1);
    run(fwp_pkg::CMD_ERASE_BULK, 0, 1, 1);
  endtask

  task automatic t_asp();
    sec(3);
    chk(r[3:0], 4'hB);
    run(fwp_pkg::CMD_DSB_WRITE, 3, 0, 1);
    chk(sectorProt, 64'h8);
    run(fwp_pkg::CMD_PROGRAM, 3, 1, 0);
    run(fwp_pkg::CMD_DSB_WRITE, 32'h10003, 0, 1);
    run(fwp_pkg::CMD_PSB_PROG, 5, 1, 1);
    sec(5);
    chk(r[3:0], 4'hD);
    chk(sectorProt, 64'h20);
    run(fwp_pkg::CMD_LOCK_WRITE, 0, 0, 1);
    sec(5);
    chk(r[3], 0);
    run(fwp_pkg::CMD_PSB_ERASE, 0, 1, 0);
    run(fwp_pkg::CMD_PSB_PROG, 6, 1, 0);
    run(fwp_pkg::CMD_DSB_WRITE, 7, 0, 1);
    run(fwp_pkg::CMD_WRITE_ENABLE_CMD, 0, 0, 1);
    frozen_rst();
    hwrst();
    rdr(fwp_pkg::REG_STATUS);
    chk(r[fwp_pkg::ST_WEL], 0);
    chk(sectorProt, 64'h20);
    sec(5);
    chk(r[3], 1);
    run(fwp_pkg::CMD_PSB_ERASE, 0, 1, 1);
    chk(sectorProt, 64'h0);
  endtask

  task automatic t_otp();
    run(fwp_pkg::CMD_OTP_PROG, 32'hFD0010, 1, 1);
    chk(opReq.target, 16'h0010);
    chk(opReq.data, 8'hFD);
    rdr(fwp_pkg::REG_OTP_LOCK);
    chk(r, 32'hFFFFFFFD);
    run(fwp_pkg::CMD_OTP_PROG, 32'h30, 1, 0);
    run(fwp_pkg::CMD_OTP_PROG, 32'h40, 1, 1);
    run(fwp_pkg::CMD_OTP_PROG, 32'hFE0011, 1, 1);
    run(fwp_pkg::CMD_OTP_PROG, 32'h100, 1, 0);
    run(fwp_pkg::CMD_OTP_PROG, 32'hFE0010, 1, 1);
    rdr(fwp_pkg::REG_OTP_LOCK);
    chk(r, 32'hFFFFFEFC);
    run(fwp_pkg::CMD_OTP_PROG, 32'h18, 1, 0);
    run(fwp_pkg::CMD_OTP_PROG, 32'h05, 1, 1);
  endtask

  task automatic t_wp_freeze();
    run(fwp_pkg::CMD_REG_WRITE, 32'h84, 1, 1);
    @(posedge clk_sys) wpPinN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    run(fwp_pkg::CMD_REG_WRITE, 32'h100, 1, 0);
    rdr(fwp_pkg::REG_STATUS);
    chk(r[7:2], 6'h21);
    rdr(fwp_pkg::REG_CONFIG);
    chk(r[0], 0);
    @(posedge clk_sys) wpPinN <= 1'b1;
    repeat (5) @(posedge clk_sys);
    run(fwp_pkg::CMD_REG_WRITE, 32'h104, 1, 1);
    // Only a power cycle clears freeze, so this runs last but one
    run(fwp_pkg::CMD_REG_WRITE, 32'h330C, 1, 1);
    rdr(fwp_pkg::REG_STATUS);
    chk(r[4:2], 3'h1);
    rdr(fwp_pkg::REG_CONFIG);
    chk(r[5], 0);
    run(fwp_pkg::CMD_OTP_PROG, 32'h60, 1, 0);
  endtask

  task automatic t_mode();
    run(fwp_pkg::CMD_GUARD_PROG, 0, 1, 0);
    rdr(fwp_pkg::REG_MODE);
    chk(r[2:1], 2'h3);
    fwp_host_model_inst.wr(fwp_pkg::REG_PASS_LO, 32'h12345678);
    fwp_host_model_inst.wr(fwp_pkg::REG_PASS_HI, 32'h9ABCDEF0);
    run(fwp_pkg::CMD_PASS_PROG, 0, 1, 1);
    run(fwp_pkg::CMD_GUARD_PROG, 2, 1, 1);
    rdr(fwp_pkg::REG_MODE);
    chk(r[2:1], 2'h1);
    run(fwp_pkg::CMD_GUARD_PROG, 4, 1, 0);
    hwrst();
    sec(0);
    chk(r[3], 0);
    fwp_host_model_inst.wr(fwp_pkg::REG_PASS_HI, 32'h9ABCDEF1);
    run(fwp_pkg::CMD_PASS_UNLOCK, 0, 0, 0);
    sec(0);
    chk(r[3], 0);
    fwp_host_model_inst.wr(fwp_pkg::REG_PASS_HI, 32'h9ABCDEF0);
    run(fwp_pkg::CMD_PASS_UNLOCK, 0, 0, 1);
    sec(0);
    chk(r[3], 1);
    run(fwp_pkg::CMD_LOCK_WRITE, 0, 0, 1);
    sec(0);
    chk(r[3], 0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn <= 1'b0;
    ce <= 1'b1;
    wpPinN <= 1'b1;
    hwResetPinN <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_wel();
    t_block();
    t_asp();
    t_otp();
    t_wp_freeze();
    t_mode();
    close_out();
  end
endmodule
